// ===== verilog/batch_sequencer.sv
// Batch sequencer: keys, relays, flow timeout and AXI4-Lite setup
`timescale 1ns/1ps
`default_nettype none
module batch_sequencer #(
  parameter int SEC_CYC = batch_pkg::SEC_CYCLES,
  parameter int LABEL_CYC = batch_pkg::LABEL_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [batch_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [batch_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Front panel and flow pins
  input wire batch_pkg::keys_t keys_n,
  input wire logic flow_in,
  // Relays, alarm, end, indicators, display
  output batch_pkg::ctl_t ctl,
  output batch_pkg::leds_t leds,
  output batch_pkg::disp_t disp_mode,
  output logic [batch_pkg::BCD_W-1:0] disp_value,
  output logic [batch_pkg::DIGITS-1:0] flash_mask
);
  import batch_pkg::*;

  localparam int CW = $clog2(SEC_CYC + 1);
  localparam int LW = $clog2(LABEL_CYC + 1);

  cfg_t cfg;
  state_t state;
  disp_t dmode;
  keys_t ks1, ks2, ks3;
  logic fs1, fs2, fs3;
  logic k_stop, k_run, k_set, k_disp, pulse, run_k;
  logic [CW-1:0] sec_cnt;
  logic tick, blink;
  logic [LW-1:0] lbl_cnt;
  logic editing, viewing, qty_err, running;
  logic [2:0] dig;
  logic [BCD_W-1:0] qty, ebuf, total, remaining, acc;
  logic [12:0] soft_s;
  logic [7:0] idle_s;
  logic tmo_on, expired, in_prestop, soft_done;
  logic go_start, go_cont, go_abort;
  logic [ADDR_W-1:0] aw_a;
  logic [31:0] wd_q, wv;
  logic [3:0] ws_q;

  function automatic logic [BCD_W-1:0] bcd_step(input logic [BCD_W-1:0] v, input logic up);
    logic [BCD_W-1:0] r;
    logic c;
    logic [3:0] d;
    r = v;
    c = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      d = v[4*i +: 4];
      if (c && up) begin
        c = (d == 4'h9);
        d = c ? 4'h0 : d + 4'h1;
      end else if (c) begin
        c = (d == 4'h0);
        d = c ? 4'h9 : d - 4'h1;
      end
      r[4*i +: 4] = d;
    end
    return r;
  endfunction : bcd_step

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = '0;
    if (a == OFS_CTRL) begin
      r[CTRL_DOWN] = cfg.down;
      r[CTRL_AUTO] = cfg.auto_rst;
    end else if (a == OFS_MAX) r[BCD_W-1:0] = cfg.max_qty;
    else if (a == OFS_PRESTOP) r[BCD_W-1:0] = cfg.prestop;
    else if (a == OFS_SOFT) r[12:0] = cfg.soft_s;
    else if (a == OFS_TMO) r[6:0] = cfg.tmo_s;
    else if (a == OFS_STATUS) r[6:0] = {ctl.end_of_batch, qty_err, viewing, editing, state};
    else if (a == OFS_QTY) r[BCD_W-1:0] = qty;
    else if (a == OFS_TOTAL) r[BCD_W-1:0] = total;
    else if (a == OFS_ACC) r[BCD_W-1:0] = acc;
    return r;
  endfunction : rd_word

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a <= OFS_ACC && a[1:0] == 2'b00;
  endfunction : mapped

  // Pin synchronisers and press detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ks1 <= '0;
      ks2 <= '0;
      ks3 <= '0;
      fs1 <= 1'b0;
      fs2 <= 1'b0;
      fs3 <= 1'b0;
    end else begin
      ks1 <= ~keys_n;
      ks2 <= ks1;
      ks3 <= ks2;
      fs1 <= flow_in;
      fs2 <= fs1;
      fs3 <= fs2;
    end
  end
  assign k_stop = ks2.stop & ~ks3.stop;
  assign k_run = ks2.run & ~ks3.run;
  assign k_set = ks2.set & ~ks3.set;
  assign k_disp = ks2.disp & ~ks3.disp;
  assign pulse = fs2 & ~fs3;

  // One second tick and blink
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt <= '0;
      tick <= 1'b0;
      blink <= 1'b0;
    end else begin
      tick <= (sec_cnt == CW'(SEC_CYC - 1));
      sec_cnt <= (sec_cnt == CW'(SEC_CYC - 1)) ? '0 : sec_cnt + 1'b1;
      if (tick) blink <= ~blink;
    end
  end

  // AXI4-Lite write channel and configuration
  always_comb wv = merge(rd_word(aw_a), wd_q, ws_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_a <= '0;
      wd_q <= '0;
      ws_q <= '0;
      cfg <= '{down: 1'b0, auto_rst: 1'b0, max_qty: MAX_RESET, prestop: BCD_ZERO, soft_s: '0, tmo_s: '0};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_a <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_a) ? RESP_OKAY : RESP_SLVERR;
        if (aw_a == OFS_CTRL) begin
          cfg.down <= wv[CTRL_DOWN];
          cfg.auto_rst <= wv[CTRL_AUTO];
        end else if (aw_a == OFS_MAX) cfg.max_qty <= wv[BCD_W-1:0];
        else if (aw_a == OFS_PRESTOP) cfg.prestop <= wv[BCD_W-1:0];
        else if (aw_a == OFS_SOFT) cfg.soft_s <= (|wv[31:13] || wv[12:0] > SOFT_MAX_S) ? SOFT_MAX_S : wv[12:0];
        else if (aw_a == OFS_TMO) cfg.tmo_s <= (|wv[31:7] || wv[6:0] > TMO_MAX_S) ? TMO_MAX_S : wv[6:0];
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word({s_axi_araddr[ADDR_W-1:2], 2'b00});
      s_axi_rresp <= mapped({s_axi_araddr[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Quantity entry and display selection
  assign running = (state == ST_RUN) || (state == ST_OVER);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      editing <= 1'b0;
      viewing <= 1'b0;
      qty_err <= 1'b0;
      dig <= TOP_DIG;
      ebuf <= BCD_ZERO;
      qty <= QTY_RESET;
      dmode <= DM_TOTAL;
      lbl_cnt <= '0;
    end else begin
      if (viewing && !running) viewing <= 1'b0;
      if (lbl_cnt != '0) lbl_cnt <= lbl_cnt - 1'b1;
      if (lbl_cnt == LW'(1)) begin
        case (dmode)
          DM_BATCH_LBL: dmode <= DM_QTY;
          DM_RATE_LBL: dmode <= DM_RATE;
          DM_ACC_LBL: dmode <= DM_ACC;
          DM_SET_LBL: dmode <= DM_TOTAL;
          default: dmode <= dmode;
        endcase
      end
      if (k_set) begin
        if (editing && ebuf > cfg.max_qty) begin
          qty_err <= 1'b1;
        end else if (editing) begin
          qty <= ebuf;
          editing <= 1'b0;
          qty_err <= 1'b0;
          dmode <= DM_SET_LBL;
          lbl_cnt <= LW'(LABEL_CYC);
        end else if (viewing) begin
          viewing <= 1'b0;
          dmode <= DM_TOTAL;
        end else begin
          editing <= !running;
          viewing <= running;
          ebuf <= qty;
          dig <= TOP_DIG;
          dmode <= DM_BATCH_LBL;
          lbl_cnt <= LW'(LABEL_CYC);
        end
      end else if (editing && k_disp) begin
        ebuf[4*dig +: 4] <= (ebuf[4*dig +: 4] == 4'h9) ? 4'h0 : ebuf[4*dig +: 4] + 4'h1;
      end else if (editing && k_run) begin
        dig <= (dig == 3'h0) ? TOP_DIG : dig - 3'h1;
      end else if (!editing && !viewing && k_disp) begin
        lbl_cnt <= LW'(LABEL_CYC);
        case (dmode)
          DM_TOTAL: dmode <= DM_RATE_LBL;
          DM_RATE_LBL, DM_RATE: dmode <= DM_ACC_LBL;
          default: begin
            dmode <= DM_TOTAL;
            lbl_cnt <= '0;
          end
        endcase
      end
    end
  end

  // Batch conditions
  assign run_k = k_run && !editing;
  assign tmo_on = cfg.tmo_s != '0;
  assign expired = tmo_on && idle_s > {1'b0, cfg.tmo_s};
  assign in_prestop = remaining <= cfg.prestop;
  assign soft_done = soft_s >= cfg.soft_s;
  assign go_start = run_k && (state == ST_IDLE || (state == ST_DONE && cfg.auto_rst));
  assign go_cont = run_k && (state == ST_PAUSE || state == ST_ACK);
  assign go_abort = k_stop && (state == ST_PAUSE || state == ST_ACK || state == ST_DONE);

  // Batch state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (go_start) state <= ST_RUN;
        ST_RUN: begin
          if (k_stop) state <= ST_PAUSE;
          else if (expired) state <= ST_ALARM;
          else if (remaining == BCD_ZERO) state <= tmo_on ? ST_OVER : ST_DONE;
        end
        ST_OVER: if (expired) state <= ST_DONE;
        ST_PAUSE: begin
          if (go_abort) state <= ST_IDLE;
          else if (go_cont) state <= ST_RUN;
        end
        ST_ALARM: if (k_stop) state <= ST_ACK;
        ST_ACK: begin
          if (go_abort) state <= ST_IDLE;
          else if (go_cont) state <= ST_RUN;
        end
        ST_DONE: begin
          if (go_abort) state <= ST_IDLE;
          else if (go_start) state <= ST_RUN;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Totals and timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total <= BCD_ZERO;
      remaining <= BCD_ZERO;
      acc <= BCD_ZERO;
      soft_s <= '0;
      idle_s <= '0;
    end else begin
      if (pulse) acc <= bcd_step(acc, 1'b1);
      if (pulse || go_start || go_cont) idle_s <= '0;
      else if (tick && idle_s != 8'hff) idle_s <= idle_s + 8'h01;
      if (go_start || go_abort) begin
        remaining <= qty;
        total <= cfg.down ? qty : BCD_ZERO;
      end else if (pulse && state != ST_IDLE && state != ST_DONE) begin
        if (remaining != BCD_ZERO) remaining <= bcd_step(remaining, 1'b0);
        if (!cfg.down) total <= bcd_step(total, 1'b1);
        else if (total != BCD_ZERO) total <= bcd_step(total, 1'b0);
      end
      if (go_start || (go_cont && !in_prestop)) soft_s <= '0;
      else if (tick && state == ST_RUN && !soft_done) soft_s <= soft_s + 13'h0001;
    end
  end

  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= '0;
      leds <= '0;
      disp_mode <= DM_TOTAL;
      disp_value <= BCD_ZERO;
      flash_mask <= '0;
    end else begin
      ctl.relay1 <= state == ST_RUN;
      ctl.relay2 <= state == ST_RUN && soft_done && !in_prestop;
      ctl.flow_alarm <= state == ST_ALARM;
      ctl.end_of_batch <= state == ST_DONE;
      leds.run <= running;
      leds.stop <= (state == ST_PAUSE || state == ST_ALARM) && blink;
      leds.set <= editing;
      disp_mode <= dmode;
      if (dmode == DM_QTY) disp_value <= editing ? ebuf : qty;
      else if (dmode == DM_ACC) disp_value <= acc;
      else if (dmode == DM_TOTAL) disp_value <= total;
      else disp_value <= BCD_ZERO;
      if (dmode == DM_QTY && editing) flash_mask <= {{(DIGITS-1){1'b0}}, 1'b1} << dig;
      else if (dmode == DM_QTY && viewing) flash_mask <= {DIGITS{1'b1}};
      else flash_mask <= '0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SOFT_START: assert property ($rose(ctl.relay2) |-> $past(soft_s) >= $past(cfg.soft_s))
    else $error("relay two before soft delay");
  AST_STOP_RELAYS: assert property ((k_stop && state == ST_RUN) |-> ##2 (!ctl.relay1 && !ctl.relay2))
    else $error("relays on after stop");
  AST_ALARM: assert property ((state == ST_RUN && expired && !k_stop) |-> ##2 (ctl.flow_alarm && !ctl.relay1))
    else $error("no alarm on flow loss");
  AST_ALARM_HOLD: assert property ((state == ST_ALARM && !k_stop) |=> state == ST_ALARM)
    else $error("alarm dropped without stop");
  AST_EOB_ZERO_TMO: assert property ((state == ST_RUN && remaining == BCD_ZERO && !tmo_on && !k_stop)
    |=> state == ST_DONE)
    else $error("end not declared at quantity");
  AST_NO_EDIT_RUN: assert property ((k_set && !viewing && running) |=> !editing)
    else $error("edit while running");
  AST_MAX_REJECT: assert property ((k_set && editing && ebuf > cfg.max_qty) |=> qty == $past(qty))
    else $error("quantity above limit stored");
  AST_EOB_HOLD: assert property ((state == ST_DONE && !go_abort && !go_start) |=> ##1 ctl.end_of_batch)
    else $error("end output dropped");
  AST_DOWN_LOAD: assert property ((go_start && cfg.down) |=> total == $past(qty))
    else $error("count down not loaded");
  AST_OVER_REFUSE: assert property ((state == ST_OVER && k_stop && !expired) |=> state == ST_OVER)
    else $error("reset before end of batch");

  COV_PAUSE: cover property (state == ST_PAUSE ##1 go_cont);
  COV_ALARM: cover property (state == ST_ALARM ##[1:20] state == ST_ACK);
  COV_DONE: cover property (state == ST_OVER ##[1:50] state == ST_DONE);
  COV_ACCEPT: cover property (k_set && editing && ebuf <= cfg.max_qty);
endmodule : batch_sequencer
`default_nettype wire

// ===== pkg/batch_pkg.sv
// Constants, register map and carrier types for the batch sequencer
package batch_pkg;
  localparam int DIGITS = 6;
  localparam int BCD_W = 4 * DIGITS;
  localparam int ADDR_W = 8;
  localparam int CLK_NS = 10;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_NS;
  localparam int LABEL_NS = SEC_NS;
  localparam int LABEL_CYCLES = LABEL_NS / CLK_NS;
  localparam logic [12:0] SOFT_MAX_S = 13'h12bf;
  localparam logic [6:0] TMO_MAX_S = 7'h63;
  localparam logic [2:0] TOP_DIG = 3'(DIGITS - 1);
  localparam logic [BCD_W-1:0] QTY_RESET = 24'h00_0000;
  localparam logic [BCD_W-1:0] BCD_ZERO = 24'h00_0000;
  localparam logic [BCD_W-1:0] MAX_RESET = 24'h99_9999;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MAX = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRESTOP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SOFT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TMO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_QTY = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TOTAL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h20;
  localparam int CTRL_DOWN = 0;
  localparam int CTRL_AUTO = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RUN = 3'h1, ST_OVER = 3'h3, ST_DONE = 3'h2,
    ST_PAUSE = 3'h6, ST_ALARM = 3'h7, ST_ACK = 3'h5
  } state_t;

  typedef enum logic [2:0] {
    DM_TOTAL, DM_RATE_LBL, DM_RATE, DM_ACC_LBL, DM_ACC, DM_BATCH_LBL, DM_QTY, DM_SET_LBL
  } disp_t;

  typedef struct packed {
    logic down;
    logic auto_rst;
    logic [BCD_W-1:0] max_qty;
    logic [BCD_W-1:0] prestop;
    logic [12:0] soft_s;
    logic [6:0] tmo_s;
  } cfg_t;

  typedef struct packed {
    logic stop;
    logic run;
    logic set;
    logic disp;
  } keys_t;

  typedef struct packed {
    logic relay1;
    logic relay2;
    logic flow_alarm;
    logic end_of_batch;
  } ctl_t;

  typedef struct packed {
    logic run;
    logic stop;
    logic set;
  } leds_t;
endpackage : batch_pkg

// ===== dv/panel_model.sv
// Operator keypad and flow pulse source facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  // Clock
  input wire logic aclk,
  // Pins toward the sequencer
  output var batch_pkg::keys_t keys_n,
  output var logic flow_in
);
  import batch_pkg::*;
  initial begin
    keys_n = 4'hf;
    flow_in = 1'b0;
  end
  // Held low, then released so the next press is a fresh edge
  task automatic press(input int k);
    @(posedge aclk);
    keys_n[k] <= 1'b0;
    repeat (4) @(posedge aclk);
    keys_n[k] <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : press
  // One flow count, then a quiet gap
  task automatic pulse(input int gap);
    @(posedge aclk);
    flow_in <= 1'b1;
    repeat (3) @(posedge aclk);
    flow_in <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask : pulse
endmodule : panel_model
`default_nettype wire

// ===== dv/batch_sequencer_test.sv
// Self-checking bench for the batch sequencer
`timescale 1ns/1ps
`default_nettype none
module batch_sequencer_test;
  import batch_pkg::*;
  localparam int K_STOP = 3;
  localparam int K_RUN = 2;
  localparam int K_SET = 1;
  localparam int K_DISP = 0;
  localparam int SEC_TB = 20;
  localparam logic [39:0] M_CTL = 40'h00_0000_000f;
  localparam logic [39:0] M_MODE = 40'h00_0000_e000;
  localparam logic [39:0] M_VAL = 40'hff_ffff_e000;
  typedef struct {
    string what;
    logic [39:0] val;
    logic [39:0] mask;
  } note_t;
  note_t notes[$];
  int err_total = 0;
  int n_compared = 0;
  logic [16:0] rnd = 17'h1_75ee;
  logic aclk, aresetn, snap, flash_rdy;
  logic [7:0] flash_cnt;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  keys_t keys_n;
  logic flow_in;
  ctl_t ctl;
  leds_t leds;
  disp_t disp_mode;
  logic [BCD_W-1:0] disp_value;
  logic [DIGITS-1:0] flash_mask;

  batch_sequencer #(.SEC_CYC(SEC_TB), .LABEL_CYC(10)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .keys_n(keys_n), .flow_in(flow_in), .ctl(ctl), .leds(leds),
    .disp_mode(disp_mode), .disp_value(disp_value), .flash_mask(flash_mask)
  );
  panel_model m (.aclk(aclk), .keys_n(keys_n), .flow_in(flow_in));

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next

  task automatic give_verdict();
    $display("Counts: compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic take(input logic [39:0] seen);
    note_t n;
    n_compared++;
    if (notes.size() == 0) begin
      $display("ERROR result expected none seen %h", seen);
      err_total++;
      return;
    end
    n = notes.pop_front();
    if ((seen & n.mask) !== (n.val & n.mask)) begin
      $display("ERROR %s expected %h seen %h", n.what, n.val & n.mask, seen & n.mask);
      err_total++;
    end
  endtask : take

  // Result watcher: each answer takes the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) take({6'h00, s_axi_rresp, s_axi_rdata});
    else if (s_axi_bvalid && s_axi_bready) take({6'h00, s_axi_bresp, 32'h0000_0000});
    else if (snap) take({disp_value, disp_mode, flash_mask, leds, ctl});
    else if (flash_rdy) take({32'h0000_0000, flash_cnt});
  end

  task automatic hang(input string what);
    $display("ERROR %s expected answer seen none", what);
    err_total++;
    give_verdict();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    notes.push_back('{"bresp", {6'h00, RESP_OKAY, 32'h0000_0000}, 40'h03_0000_0000});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50) hang("write");
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [1:0] r, input logic [31:0] d,
                    input logic [31:0] mk);
    int i;
    notes.push_back('{what, {6'h00, r, d}, {6'h00, 2'h3, mk}});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50) hang(what);
  endtask : rd

  task automatic st(input logic [31:0] d, input logic [31:0] mk);
    rd("status", OFS_STATUS, RESP_OKAY, d, mk);
  endtask : st

  task automatic chk(input string what, input logic [39:0] v, input logic [39:0] mk);
    @(posedge aclk);
    notes.push_back('{what, v, mk});
    snap <= 1'b1;
    @(posedge aclk);
    snap <= 1'b0;
  endtask : chk

  // Stop indicator high for half of any two-second window
  task automatic flashes(input string what);
    int hi;
    hi = 0;
    notes.push_back('{what, 40'(SEC_TB), 40'h00_0000_00ff});
    repeat (2 * SEC_TB) begin
      @(posedge aclk);
      if (leds.stop === 1'b1) hi++;
    end
    flash_cnt <= 8'(hi);
    flash_rdy <= 1'b1;
    @(posedge aclk);
    flash_rdy <= 1'b0;
  endtask : flashes

  task automatic flow(input int n);
    repeat (n) begin
      m.pulse(3 + int'(rnd[1:0]));
      rnd = lfsr_next(rnd);
    end
  endtask : flow

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    hang("watchdog");
  end

  initial begin
    {aresetn, snap, flash_rdy, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, flash_cnt} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd("ctrl", OFS_CTRL, RESP_OKAY, 32'h0000_0000, 32'hffff_ffff);
    rd("max", OFS_MAX, RESP_OKAY, 32'h0099_9999, 32'hffff_ffff);
    rd("unmapped", 8'h24, RESP_SLVERR, 32'h0000_0000, 32'hffff_ffff);
    $display("test reset done");
    wr(OFS_MAX, 32'h0000_0003);
    m.press(K_SET);
    chk("label", {24'h00_0000, DM_BATCH_LBL, 13'h0000}, M_MODE);
    repeat (12) @(posedge aclk);
    chk("edit", {24'h00_0000, DM_QTY, 6'h20, 3'h1, 4'h0}, 40'h00_0000_ff90);
    repeat (5) m.press(K_RUN);
    repeat (4) m.press(K_DISP);
    chk("digit", {24'h00_0004, DM_QTY, 6'h01, 3'h1, 4'h0}, 40'hff_ffff_ff90);
    m.press(K_SET);
    st(32'h0000_0028, 32'h0000_0028);
    wr(OFS_MAX, 32'h0099_9999);
    m.press(K_SET);
    chk("accept", {24'h00_0000, DM_SET_LBL, 6'h00, 3'h0, 4'h0}, 40'h00_0000_e010);
    st(32'h0000_0000, 32'h0000_0008);
    rd("qty", OFS_QTY, RESP_OKAY, 32'h0000_0004, 32'hffff_ffff);
    repeat (12) @(posedge aclk);
    m.press(K_DISP);
    chk("rate label", {24'h00_0000, DM_RATE_LBL, 13'h0000}, M_MODE);
    repeat (12) @(posedge aclk);
    chk("rate", {24'h00_0000, DM_RATE, 13'h0000}, M_VAL);
    m.press(K_DISP);
    chk("acc label", {24'h00_0000, DM_ACC_LBL, 13'h0000}, M_MODE);
    repeat (12) @(posedge aclk);
    chk("acc view", {24'h00_0000, DM_ACC, 13'h0000}, M_VAL);
    $display("test entry done");
    wr(OFS_PRESTOP, 32'h0000_0002);
    wr(OFS_SOFT, 32'h0000_0002);
    m.press(K_RUN);
    chk("start", 40'h00_0000_0048, 40'h00_0000_004f);
    repeat (70) @(posedge aclk);
    chk("soft", 40'h00_0000_000c, M_CTL);
    flow(2);
    chk("prestop", 40'h00_0000_0008, M_CTL);
    flow(2);
    chk("end", 40'h00_0000_0001, M_CTL);
    rd("total", OFS_TOTAL, RESP_OKAY, 32'h0000_0004, 32'hffff_ffff);
    m.press(K_RUN);
    chk("held", 40'h00_0000_0001, M_CTL);
    m.press(K_STOP);
    chk("reset", 40'h00_0000_0000, M_CTL);
    rd("total", OFS_TOTAL, RESP_OKAY, 32'h0000_0000, 32'hffff_ffff);
    $display("test count up done");
    m.press(K_RUN);
    repeat (70) @(posedge aclk);
    m.press(K_SET);
    st(32'h0000_0011, 32'h0000_001f);
    repeat (12) @(posedge aclk);
    chk("view", {24'h00_0004, DM_QTY, 6'h3f, 3'h4, 4'hc}, 40'hff_ffff_ff80);
    m.press(K_STOP);
    chk("pause", 40'h00_0000_0000, M_CTL);
    st(32'h0000_0006, 32'h0000_0007);
    flashes("stop flash");
    m.press(K_RUN);
    chk("continue", 40'h00_0000_0008, M_CTL);
    m.press(K_STOP);
    m.press(K_STOP);
    st(32'h0000_0000, 32'h0000_0007);
    $display("test pause done");
    wr(OFS_TMO, 32'h0000_0001);
    m.press(K_RUN);
    repeat (90) @(posedge aclk);
    chk("alarm", 40'h00_0000_0002, M_CTL);
    st(32'h0000_0007, 32'h0000_0007);
    flashes("alarm flash");
    m.press(K_STOP);
    chk("ack", 40'h00_0000_0000, M_CTL);
    st(32'h0000_0005, 32'h0000_0007);
    m.press(K_STOP);
    st(32'h0000_0000, 32'h0000_0007);
    $display("test alarm done");
    m.press(K_RUN);
    flow(5);
    m.press(K_STOP);
    st(32'h0000_0003, 32'h0000_0007);
    repeat (60) @(posedge aclk);
    chk("end", 40'h00_0000_0001, M_CTL);
    rd("total", OFS_TOTAL, RESP_OKAY, 32'h0000_0005, 32'hffff_ffff);
    m.press(K_STOP);
    st(32'h0000_0000, 32'h0000_0007);
    $display("test overrun done");
    wr(OFS_CTRL, 32'h0000_0003);
    wr(OFS_TMO, 32'h0000_0000);
    wr(OFS_SOFT, 32'h0000_0000);
    wr(OFS_PRESTOP, 32'h0000_0000);
    m.press(K_RUN);
    rd("total", OFS_TOTAL, RESP_OKAY, 32'h0000_0004, 32'hffff_ffff);
    flow(4);
    chk("end", 40'h00_0000_0001, M_CTL);
    m.press(K_RUN);
    chk("auto", 40'h00_0000_0008, 40'h00_0000_000b);
    rd("total", OFS_TOTAL, RESP_OKAY, 32'h0000_0004, 32'hffff_ffff);
    m.press(K_STOP);
    m.press(K_STOP);
    rd("acc", OFS_ACC, RESP_OKAY, 32'h0000_0013, 32'hffff_ffff);
    wr(OFS_ACC, 32'h0000_0000);
    rd("acc", OFS_ACC, RESP_OKAY, 32'h0000_0013, 32'hffff_ffff);
    $display("test count down done");
    repeat (5) @(posedge aclk);
    if (notes.size() != 0) begin
      $display("ERROR pending expected 0 seen %0d", notes.size());
      err_total++;
    end
    give_verdict();
  end
endmodule : batch_sequencer_test
`default_nettype wire
